// *** shared/rosc_pkg.sv ***
// Package with register map, field positions and encodings of the receive offset/sync control.
package rosc_pkg;
	localparam logic [7:0] ADDR_RX_CTRL_FIRST  = 8'h24;
	localparam logic [7:0] ADDR_RX_CTRL_SECOND = 8'h25;
	localparam logic [7:0] ADDR_STATUS         = 8'h26;
	localparam logic [7:0] ADDR_FUNC           = 8'h27;
	localparam logic [7:0] RST_RX_CTRL_FIRST   = 8'h00;
	localparam logic [7:0] RST_RX_CTRL_SECOND  = 8'h9c;
	localparam logic [7:0] RST_FUNC            = 8'h00;
	localparam int BIT_SW_DISABLE  = 7;
	localparam int BIT_FOUR_ERR    = 6;
	localparam int BIT_AUTO_AUTO_CRC_INVERT_ENABLE   = 5;
	localparam int BIT_FORCED_AUTO_CRC_INVERT_ENABLE = 4;
	localparam int BIT_LINE_POL    = 3;
	localparam logic [2:0] ERR_LIMIT_THREE = 3'h3;
	localparam logic [2:0] ERR_LIMIT_FOUR  = 3'h4;
	localparam logic [2:0] PORT_FUNC_SYNC   = 3'h0;
	localparam logic [2:0] PORT_FUNC_MARKER = 3'h1;
	localparam logic [10:0] OFFSET_MAX = 11'h7ff;
	localparam logic [10:0] FRAME_LAST_X1 = 11'h0ff;
	localparam logic [10:0] FRAME_LAST_X2 = 11'h1ff;
	localparam logic [10:0] FRAME_LAST_X4 = 11'h3ff;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rosc_bus_s;

	typedef struct packed {
		logic fas_checked;
		logic fas_bad;
		logic sw_checked;
		logic sw_bad;
		logic crc_checked;
		logic crc_err;
		logic crc_slot;
	} rosc_frm_s;
endpackage

// *** logic/rosc_core.sv ***
// Receive offset, sync-loss criterion and CRC inversion control.
`timescale 1ns/100ps
`default_nettype none
module rosc_core (
	input  wire logic                clk_sys,
	input  wire logic                srst,
	input  wire rosc_pkg::rosc_bus_s bus,
	output logic [7:0]               rdata,
	input  wire rosc_pkg::rosc_frm_s frm,
	input  wire logic                receive_system_clock,
	input  wire logic                receive_sync_pulse_n,
	output logic                     receive_frame_marker,
	output logic                     receive_frame_marker_oe,
	output logic [10:0]              receive_bit_count,
	output logic                     sync_lost,
	output logic                     crc_invert,
	output logic                     line_input_polarity
);
	import rosc_pkg::*;

	logic [7:0]  ctrl1_reg;
	logic [7:0]  ctrl2_reg;
	logic [7:0]  func_reg;
	logic [7:0]  rdata_reg;
	logic [2:0]  fas_cnt_reg;
	logic [2:0]  sw_cnt_reg;
	logic        sync_lost_reg;
	logic        crc_err_prev_reg;
	logic        crc_inv_reg;
	logic [1:0]  clk_sync_reg;
	logic [1:0]  pulse_sync_reg;
	logic        clk_prev_reg;
	logic [10:0] bit_cnt_reg;
	logic        marker_reg;

	wire [2:0]  port_func     = func_reg[2:0];
	wire [1:0]  rate_sel      = func_reg[5:4];
	wire        sw_disable    = ctrl1_reg[BIT_SW_DISABLE];
	wire        four_err      = ctrl1_reg[BIT_FOUR_ERR];
	wire        auto_auto_crc_invert_enable     = ctrl1_reg[BIT_AUTO_AUTO_CRC_INVERT_ENABLE];
	wire        forced_auto_crc_invert_enable   = ctrl1_reg[BIT_FORCED_AUTO_CRC_INVERT_ENABLE];
	wire [10:0] receive_offset_value = {ctrl1_reg[2:0], ctrl2_reg};
	wire [2:0]  err_limit     = four_err ? ERR_LIMIT_FOUR : ERR_LIMIT_THREE;
	wire        wr_first      = bus.wr && (bus.addr == ADDR_RX_CTRL_FIRST);
	wire        wr_second     = bus.wr && (bus.addr == ADDR_RX_CTRL_SECOND);
	wire        wr_func_raw   = bus.wr && (bus.addr == ADDR_FUNC);
	// a function code other than sync or marker is not accepted
	wire        func_legal    = (bus.wdata[2:0] == PORT_FUNC_SYNC) ||
	                            (bus.wdata[2:0] == PORT_FUNC_MARKER);
	wire        wr_func       = wr_func_raw && func_legal;
	wire        sys_edge      = clk_sync_reg[1] && !clk_prev_reg;
	wire        pulse_active  = !pulse_sync_reg[1];
	// frame length 256 times clock ratio
	wire [10:0] frame_last    = (rate_sel == 2'h0) ? FRAME_LAST_X1 :
	                            (rate_sel == 2'h1) ? FRAME_LAST_X2 :
	                            (rate_sel == 2'h2) ? FRAME_LAST_X4 :
	                            OFFSET_MAX;
	wire [10:0] cnt_wrap      = (bit_cnt_reg >= frame_last) ? 11'h000 :
	                            11'(bit_cnt_reg + 11'h001);
	wire        sw_loss       = !sw_disable && (sw_cnt_reg >= err_limit);
	wire        fas_loss      = fas_cnt_reg >= err_limit;
	wire [2:0]  fas_cnt_next  = !frm.fas_checked ? fas_cnt_reg :
	                            !frm.fas_bad ? 3'h0 :
	                            (fas_cnt_reg == ERR_LIMIT_FOUR) ? fas_cnt_reg :
	                            3'(fas_cnt_reg + 3'h1);
	wire [2:0]  sw_cnt_next   = !frm.sw_checked ? sw_cnt_reg :
	                            !frm.sw_bad ? 3'h0 :
	                            (sw_cnt_reg == ERR_LIMIT_FOUR) ? sw_cnt_reg :
	                            3'(sw_cnt_reg + 3'h1);
	wire        mode_marker   = port_func == PORT_FUNC_MARKER;
	wire        mode_sync     = port_func == PORT_FUNC_SYNC;
	wire [7:0]  rd_mux        = (bus.addr == ADDR_RX_CTRL_FIRST)  ? ctrl1_reg :
	                            (bus.addr == ADDR_RX_CTRL_SECOND) ? ctrl2_reg :
	                            (bus.addr == ADDR_FUNC)           ? func_reg :
	                            (bus.addr == ADDR_STATUS)         ?
	                            {5'h00, crc_inv_reg, crc_err_prev_reg, sync_lost_reg} :
	                            8'h00;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl1_reg <= RST_RX_CTRL_FIRST;
			ctrl2_reg <= RST_RX_CTRL_SECOND;
			func_reg  <= RST_FUNC;
			rdata_reg <= 8'h00;
		end else begin
			if (wr_first) begin
				ctrl1_reg <= bus.wdata;
			end
			if (wr_second) begin
				ctrl2_reg <= bus.wdata;
			end
			if (wr_func) begin
				func_reg <= {2'h0, bus.wdata[5:4], 1'b0, bus.wdata[2:0]};
			end
			rdata_reg <= bus.rd ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fas_cnt_reg   <= 3'h0;
			sw_cnt_reg    <= 3'h0;
			sync_lost_reg <= 1'b0;
		end else begin
			fas_cnt_reg   <= fas_cnt_next;
			sw_cnt_reg    <= sw_cnt_next;
			sync_lost_reg <= fas_loss || sw_loss;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			crc_err_prev_reg <= 1'b0;
			crc_inv_reg      <= 1'b0;
		end else begin
			if (frm.crc_checked) begin
				crc_err_prev_reg <= frm.crc_err;
			end
			crc_inv_reg <= frm.crc_slot && (forced_auto_crc_invert_enable || (auto_auto_crc_invert_enable && crc_err_prev_reg));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			clk_sync_reg   <= 2'h0;
			pulse_sync_reg <= 2'h3;
			clk_prev_reg   <= 1'b0;
		end else begin
			clk_sync_reg   <= {clk_sync_reg[0], receive_system_clock};
			pulse_sync_reg <= {pulse_sync_reg[0], receive_sync_pulse_n};
			clk_prev_reg   <= clk_sync_reg[1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bit_cnt_reg <= 11'h000;
			marker_reg  <= 1'b0;
		end else if (sys_edge) begin
			// in sync mode, pulse loads offset on clock edge
			if (mode_sync && pulse_active) begin
				bit_cnt_reg <= receive_offset_value;
			end else begin
				bit_cnt_reg <= cnt_wrap;
			end
			marker_reg <= mode_marker && (cnt_wrap == receive_offset_value);
		end
	end

	assign rdata                   = rdata_reg;
	assign sync_lost               = sync_lost_reg;
	assign crc_invert              = crc_inv_reg;
	assign receive_bit_count       = bit_cnt_reg;
	assign receive_frame_marker    = marker_reg;
	// marker drives the port only in marker mode
	assign receive_frame_marker_oe = mode_marker;
	assign line_input_polarity     = ctrl1_reg[BIT_LINE_POL];
endmodule
`default_nettype wire

// *** verif/rosc_sva.sv ***
// Port checker for the receive offset and sync control block.
`timescale 1ns/100ps
`default_nettype none
module rosc_sva (
	input wire logic                clk_sys,
	input wire logic                srst,
	input wire rosc_pkg::rosc_bus_s bus,
	input wire logic [7:0]          rdata,
	input wire rosc_pkg::rosc_frm_s frm,
	input wire logic                receive_system_clock,
	input wire logic                receive_frame_marker,
	input wire logic                receive_frame_marker_oe,
	input wire logic [10:0]         receive_bit_count,
	input wire logic                sync_lost,
	input wire logic                crc_invert
);
	import rosc_pkg::*;
	logic       frc_reg;
	logic [7:0] sec_reg;
	wire logic  wr_first = bus.wr && bus.addr == ADDR_RX_CTRL_FIRST;
	wire logic  wr_sec   = bus.wr && bus.addr == ADDR_RX_CTRL_SECOND;
	always_ff @(posedge clk_sys) begin
		frc_reg <= srst ? 1'b0 : (wr_first ? bus.wdata[BIT_FORCED_AUTO_CRC_INVERT_ENABLE] : frc_reg);
		sec_reg <= srst ? RST_RX_CTRL_SECOND : (wr_sec ? bus.wdata : sec_reg);
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_rd_sec;
		bus.rd && bus.addr == ADDR_RX_CTRL_SECOND;
	endsequence
	sequence s_link_still;
		$stable(receive_system_clock) [*5];
	endsequence
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("rdata without read");
	a_second_read: assert property (s_rd_sec |=> rdata == $past(sec_reg))
		else $error("offset low readback");
	a_forced_inv: assert property (frc_reg && frm.crc_slot |=> crc_invert)
		else $error("forced inversion missing");
	a_inv_cause: assert property (crc_invert |-> $past(frm.crc_slot))
		else $error("inversion outside slot");
	a_lost_cause: assert property ($rose(sync_lost) |-> $past(frm.fas_bad | frm.sw_bad, 2))
		else $error("sync loss without bad word");
	a_count_idle: assert property (s_link_still |-> $stable(receive_bit_count))
		else $error("count moved without link edge");
	a_marker_oe: assert property (receive_frame_marker |-> receive_frame_marker_oe)
		else $error("marker outside marker mode");
	a_oe_reset: assert property ($fell(srst) |-> !receive_frame_marker_oe)
		else $error("marker enabled after reset");
endmodule
bind rosc_core rosc_sva u_sva (.*);
`default_nettype wire

// *** verif/rosc_far.sv ***
// Backplane model: free running receive clock and a sync pulse on request.
`timescale 1ns/100ps
`default_nettype none
module rosc_far (
	input  wire logic sync_req,
	output logic      receive_system_clock = 1'b0,
	output logic      receive_sync_pulse_n = 1'b1
);
	always #32 receive_system_clock = ~receive_system_clock;
	always @(negedge receive_system_clock) receive_sync_pulse_n <= ~sync_req;
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the receive offset and sync control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import rosc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        sync_req = 1'b0;
	logic        seen = 1'b0;
	rosc_bus_s   bus = '0;
	rosc_frm_s   frm = '0;
	logic [7:0]  rdata;
	logic [10:0] receive_bit_count;
	logic        receive_system_clock, receive_sync_pulse_n, receive_frame_marker;
	logic        receive_frame_marker_oe, sync_lost, crc_invert, line_input_polarity;
	int          miscompares = 0;
	int          checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge receive_frame_marker) seen = 1'b1;
	rosc_far far (.*);
	rosc_core dut (.*);
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1 chk(rdata, e);
	endtask
	task automatic fr(input rosc_frm_s f, input int n, input logic e);
		repeat (n) begin
			@(posedge clk_sys);
			frm <= f;
			@(posedge clk_sys);
			frm <= '{crc_slot: f.crc_slot, default: 1'b0};
		end
		@(posedge clk_sys);
		#1 chk(f.crc_slot ? crc_invert : sync_lost, e);
	endtask
	task automatic rst;
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		rst();
		rd(ADDR_RX_CTRL_SECOND, RST_RX_CTRL_SECOND);
		rd(8'h40, 8'h00);
		wr(ADDR_RX_CTRL_FIRST, 8'h0d);
		rd(ADDR_RX_CTRL_FIRST, 8'h0d);
		chk(line_input_polarity, 1'b1);
		fr(7'h60, 2, 1'b0);
		fr(7'h60, 1, 1'b1);
		rst();
		wr(ADDR_RX_CTRL_FIRST, 8'h40);
		fr(7'h18, 3, 1'b0);
		fr(7'h18, 1, 1'b1);
		rst();
		wr(ADDR_RX_CTRL_FIRST, 8'hc0);
		fr(7'h18, 4, 1'b0);
		fr(7'h60, 4, 1'b1);
		wr(ADDR_RX_CTRL_FIRST, 8'h20);
		fr(7'h06, 1, 1'b1);
		fr(7'h01, 1, 1'b1);
		fr(7'h04, 1, 1'b1);
		fr(7'h01, 1, 1'b0);
		wr(ADDR_RX_CTRL_FIRST, 8'h10);
		fr(7'h01, 1, 1'b1);
		wr(ADDR_RX_CTRL_FIRST, 8'h30);
		fr(7'h01, 1, 1'b1);
		sync_req <= 1'b1;
		repeat (64) @(posedge clk_sys);
		#1 chk(receive_bit_count, {3'h0, RST_RX_CTRL_SECOND});
		sync_req <= 1'b0;
		wr(ADDR_FUNC, 8'h02);
		rd(ADDR_FUNC, RST_FUNC);
		wr(ADDR_FUNC, 8'h01);
		chk(receive_frame_marker_oe, 1'b1);
		for (int i = 0; i < 4000 && !seen; i++) @(posedge clk_sys);
		#1 chk(seen, 1'b1);
		wr(ADDR_FUNC, 8'h21);
		rd(ADDR_FUNC, 8'h21);
		report_and_stop();
	end
	initial begin
		#200000;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
